// File: pkg/unlsw_pkg.sv
// Constants for the nine-bit / loop / single-wire serial block.
// Assumes a plain register port with 8-bit data and one-cycle read latency.
package unlsw_pkg;
  // Register offsets (chosen map)
  localparam logic [2:0] UNLSW_ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] UNLSW_ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] UNLSW_ADDR_STAT = 3'h2;
  localparam logic [2:0] UNLSW_ADDR_CTRL3 = 3'h3;
  localparam logic [2:0] UNLSW_ADDR_DATA = 3'h4;
  localparam logic [2:0] UNLSW_ADDR_BAUD = 3'h5;
  localparam logic [2:0] UNLSW_ADDR_STOP = 3'h6;
  // serial_control_one fields
  localparam int UNLSW_C1_LOOP = 7;
  localparam int UNLSW_C1_SRC = 5;
  localparam int UNLSW_C1_NINE = 4;
  // Control two fields
  localparam int UNLSW_C2_TE = 3;
  localparam int UNLSW_C2_RE = 2;
  // Status fields
  localparam int UNLSW_ST_TDRE = 7;
  localparam int UNLSW_ST_TC = 6;
  localparam int UNLSW_ST_RDRF = 5;
  localparam int UNLSW_ST_OR = 3;
  localparam int UNLSW_ST_FE = 1;
  localparam int UNLSW_ST_EDGE = 0;
  // serial_control_three fields
  localparam int UNLSW_C3_RX9 = 7;
  localparam int UNLSW_C3_TX9 = 6;
  localparam int UNLSW_C3_DIR = 5;
  localparam int UNLSW_C3_EDGIE = 4;
  // Stop mode codes
  localparam logic [1:0] UNLSW_STOP_NONE = 2'h0;
  localparam logic [1:0] UNLSW_STOP_ONE = 2'h1;
  localparam logic [1:0] UNLSW_STOP_TWO = 2'h2;
  localparam logic [1:0] UNLSW_STOP_THREE = 2'h3;
  // Reset values
  localparam logic [7:0] UNLSW_BAUD_RST = 8'h01;
  localparam logic [7:0] UNLSW_ZERO8 = 8'h00;
  // Timing: oversampling ticks per bit, half point
  localparam logic [3:0] UNLSW_OSR_LAST = 4'hf;
  localparam logic [3:0] UNLSW_OSR_MID = 4'h7;
  localparam logic [3:0] UNLSW_BITS8 = 4'h8;
  localparam logic [3:0] UNLSW_BITS9 = 4'h9;
  typedef enum logic [3:0] {
    UNLSW_IDLE = 4'b0001,
    UNLSW_START = 4'b0010,
    UNLSW_DATA = 4'b0100,
    UNLSW_STOPB = 4'b1000
  } unlsw_state_e;
endpackage

// File: core/unlsw_sync.sv
// Three-stage input synchroniser for pins arriving from outside the clock domain.
// Output changes only once the second and third stages agree.
`timescale 1ns/10ps
module unlsw_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      out_q <= 1'b1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign sync_out = out_q;
endmodule

// File: core/unlsw_core.sv
// Serial interface core: 8/9-bit frames, freeze in stop mode three (cleared in one and two), loop and single-wire modes.
// Assumes a one-cycle register port and an external stop-mode input from power control.
`timescale 1ns/10ps
module unlsw_core
  import unlsw_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] stop_mode_in,
  input wire logic rx_pin_in,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out,
  output logic rx_pin_used_out,
  output logic wake_out
);
  logic rx_sync;
  logic tx_sync;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] baud_q;
  logic tx9_q;
  logic rx9_q;
  logic dir_q;
  logic edgie_q;
  logic edge_flag_q;
  logic [7:0] tbuf_q;
  logic tdre_q;
  logic tc_q;
  logic [7:0] rbuf_q;
  logic rdrf_q;
  logic or_q;
  logic fe_q;
  logic [7:0] rdata_q;
  logic [7:0] bdiv_q;
  logic tick;
  unlsw_state_e tst_q;
  unlsw_state_e rst_q;
  logic [3:0] tos_q;
  logic [3:0] ros_q;
  logic [3:0] tbit_q;
  logic [3:0] rbit_q;
  logic [8:0] tsh_q;
  logic [8:0] rsh_q;
  logic tx_line;
  logic rx_line;
  logic rx_prev_q;
  logic run;
  logic lose;
  logic loop_en;
  logic single;
  logic nine;
  logic [3:0] nbits;
  logic wr_data;
  logic rd_data;
  logic rx_edge;

  unlsw_sync u_rx_sync (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .async_in(rx_pin_in), .sync_out(rx_sync));
  unlsw_sync u_tx_sync (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .async_in(tx_pin_in), .sync_out(tx_sync));

  assign run = (stop_mode_in == UNLSW_STOP_NONE);
  assign lose = sys_rst_in || (stop_mode_in == UNLSW_STOP_ONE) || (stop_mode_in == UNLSW_STOP_TWO);
  assign loop_en = ctrl1_q[UNLSW_C1_LOOP];
  assign single = loop_en && ctrl1_q[UNLSW_C1_SRC];
  assign nine = ctrl1_q[UNLSW_C1_NINE];
  assign nbits = nine ? UNLSW_BITS9 : UNLSW_BITS8;
  assign wr_data = wr_in && run && (addr_in == UNLSW_ADDR_DATA);
  assign rd_data = rd_in && run && (addr_in == UNLSW_ADDR_DATA);
  // Start bit low, data from the shifter, stop bit and idle high
  assign tx_line = (tst_q == UNLSW_DATA) ? tsh_q[0] : (tst_q != UNLSW_START);

  always_comb begin
    if (!loop_en) begin
      rx_line = rx_sync;
    end else if (!single) begin
      rx_line = tx_line;
    end else if (dir_q) begin
      rx_line = tx_line;
    end else begin
      rx_line = tx_sync;
    end
  end

  assign rx_pin_used_out = !loop_en;
  assign tx_pin_oe_out = ctrl2_q[UNLSW_C2_TE] && (!single || dir_q);
  assign tx_pin_out = tx_pin_oe_out ? tx_line : 1'b1;

  assign rx_edge = (rx_line != rx_prev_q) && (run || stop_mode_in == UNLSW_STOP_THREE);
  assign wake_out = edge_flag_q && edgie_q && (stop_mode_in == UNLSW_STOP_THREE);

  always_ff @(posedge clk_in) begin
    if (lose) begin
      rx_prev_q <= 1'b1;
    end else if (run || stop_mode_in == UNLSW_STOP_THREE) begin
      rx_prev_q <= rx_line;
    end
  end

  always_ff @(posedge clk_in) begin
    if (lose) begin
      ctrl1_q <= UNLSW_ZERO8;
      ctrl2_q <= UNLSW_ZERO8;
      baud_q <= UNLSW_BAUD_RST;
      tx9_q <= 1'b0;
      dir_q <= 1'b0;
      edgie_q <= 1'b0;
    end else if (wr_in && run) begin
      case (addr_in)
        UNLSW_ADDR_CTRL1: ctrl1_q <= wdata_in;
        UNLSW_ADDR_CTRL2: ctrl2_q <= wdata_in;
        UNLSW_ADDR_BAUD: baud_q <= wdata_in;
        UNLSW_ADDR_CTRL3: begin
          tx9_q <= wdata_in[UNLSW_C3_TX9];
          dir_q <= wdata_in[UNLSW_C3_DIR];
          edgie_q <= wdata_in[UNLSW_C3_EDGIE];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (lose) begin
      edge_flag_q <= 1'b0;
    end else if (rx_edge && ctrl2_q[UNLSW_C2_RE]) begin
      edge_flag_q <= 1'b1;
    end else if (wr_in && run && addr_in == UNLSW_ADDR_STAT && wdata_in[UNLSW_ST_EDGE]) begin
      edge_flag_q <= 1'b0;
    end
  end

  // Baud tick: 16 ticks per bit, divider value baud_q+1 clocks per tick
  always_ff @(posedge clk_in) begin
    if (lose) begin
      bdiv_q <= UNLSW_ZERO8;
    end else if (run) begin
      bdiv_q <= tick ? UNLSW_ZERO8 : bdiv_q + 8'h01;
    end
  end
  assign tick = run && (bdiv_q == baud_q);

  // Transmitter: buffer then shifter
  always_ff @(posedge clk_in) begin
    if (lose) begin
      tst_q <= UNLSW_IDLE;
      tbuf_q <= UNLSW_ZERO8;
      tdre_q <= 1'b1;
      tc_q <= 1'b1;
      tos_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= 9'h1ff;
    end else if (run) begin
      if (wr_data) begin
        tbuf_q <= wdata_in;
        tdre_q <= 1'b0;
        tc_q <= 1'b0;
      end
      case (tst_q)
        UNLSW_IDLE: begin
          if (!tdre_q && ctrl2_q[UNLSW_C2_TE] && tick) begin
            tsh_q <= {tx9_q, tbuf_q};
            tdre_q <= !wr_data;
            tos_q <= 4'h0;
            tst_q <= UNLSW_START;
          end
        end
        UNLSW_START: begin
          if (tick) begin
            tos_q <= tos_q + 4'h1;
            if (tos_q == UNLSW_OSR_LAST) begin
              tbit_q <= 4'h0;
              tst_q <= UNLSW_DATA;
            end
          end
        end
        UNLSW_DATA: begin
          if (tick) begin
            tos_q <= tos_q + 4'h1;
            if (tos_q == UNLSW_OSR_LAST) begin
              tsh_q <= {1'b1, tsh_q[8:1]};
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == nbits - 4'h1) begin
                tst_q <= UNLSW_STOPB;
              end
            end
          end
        end
        UNLSW_STOPB: begin
          if (tick) begin
            tos_q <= tos_q + 4'h1;
            if (tos_q == UNLSW_OSR_LAST) begin
              tst_q <= UNLSW_IDLE;
              tc_q <= tdre_q && !wr_data;
            end
          end
        end
        default: tst_q <= UNLSW_IDLE;
      endcase
    end
  end

  // Receiver: each bit is sampled at its middle tick
  always_ff @(posedge clk_in) begin
    if (lose) begin
      rst_q <= UNLSW_IDLE;
      ros_q <= 4'h0;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rbuf_q <= UNLSW_ZERO8;
      rx9_q <= 1'b0;
      rdrf_q <= 1'b0;
      or_q <= 1'b0;
      fe_q <= 1'b0;
    end else if (run) begin
      if (rd_data) begin
        rdrf_q <= 1'b0;
        or_q <= 1'b0;
        fe_q <= 1'b0;
      end
      if (!ctrl2_q[UNLSW_C2_RE]) begin
        rst_q <= UNLSW_IDLE;
      end else if (tick) begin
        case (rst_q)
          UNLSW_IDLE: begin
            if (!rx_line) begin
              ros_q <= 4'h0;
              rst_q <= UNLSW_START;
            end
          end
          UNLSW_START: begin
            ros_q <= ros_q + 4'h1;
            if (ros_q == UNLSW_OSR_MID) begin
              if (rx_line) begin
                rst_q <= UNLSW_IDLE;
              end else begin
                ros_q <= 4'h0;
                rbit_q <= 4'h0;
                rst_q <= UNLSW_DATA;
              end
            end
          end
          UNLSW_DATA: begin
            ros_q <= ros_q + 4'h1;
            if (ros_q == UNLSW_OSR_LAST) begin
              rsh_q <= nine ? {rx_line, rsh_q[8:1]} : {1'b0, rx_line, rsh_q[7:1]};
              rbit_q <= rbit_q + 4'h1;
              if (rbit_q == nbits - 4'h1) begin
                rst_q <= UNLSW_STOPB;
              end
            end
          end
          UNLSW_STOPB: begin
            ros_q <= ros_q + 4'h1;
            if (ros_q == UNLSW_OSR_LAST) begin
              rst_q <= UNLSW_IDLE;
              if (rdrf_q && !rd_data) begin
                or_q <= 1'b1;
              end else begin
                rbuf_q <= rsh_q[7:0];
                rx9_q <= nine ? rsh_q[8] : 1'b0;
                rdrf_q <= 1'b1;
                fe_q <= !rx_line;
              end
            end
          end
          default: rst_q <= UNLSW_IDLE;
        endcase
      end
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= UNLSW_ZERO8;
    end else if (rd_in) begin
      case (addr_in)
        UNLSW_ADDR_CTRL1: rdata_q <= ctrl1_q;
        UNLSW_ADDR_CTRL2: rdata_q <= ctrl2_q;
        UNLSW_ADDR_STAT: rdata_q <= {tdre_q, tc_q, rdrf_q, 1'b0, or_q, 1'b0, fe_q, edge_flag_q};
        UNLSW_ADDR_CTRL3: rdata_q <= {rx9_q, tx9_q, dir_q, edgie_q, 4'h0};
        UNLSW_ADDR_DATA: rdata_q <= rbuf_q;
        UNLSW_ADDR_BAUD: rdata_q <= baud_q;
        UNLSW_ADDR_STOP: rdata_q <= {6'h00, stop_mode_in};
        default: rdata_q <= UNLSW_ZERO8;
      endcase
    end else begin
      rdata_q <= UNLSW_ZERO8;
    end
  end
  assign rdata_out = rdata_q;
endmodule

// File: test/unlsw_core_assertions.sv
// Port checker for the serial core.
// Sees only the core's ports; bound below.
`timescale 1ns/10ps
module unlsw_chk
  import unlsw_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] stop_mode_in,
  input wire logic rx_pin_in,
  input wire logic tx_pin_in,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe_out,
  input wire logic rx_pin_used_out,
  input wire logic wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  idle_high_a: assert property (!tx_pin_oe_out |-> tx_pin_out) else $error("pin not idle");
  stop3_freeze_a: assert property (stop_mode_in == 2'h3 && $past(stop_mode_in) == 2'h3 |->
    $stable(tx_pin_out) && $stable(tx_pin_oe_out) && $stable(rx_pin_used_out)) else $error("moved in stop");
  stop_clear_a: assert property (stop_mode_in inside {2'h1, 2'h2} |=>
    !tx_pin_oe_out && tx_pin_out && rx_pin_used_out) else $error("not cleared in stop");
  wake_stop3_a: assert property (wake_out |-> stop_mode_in == 2'h3) else $error("wake outside stop");
  wake_hold_a: assert property ($past(wake_out) && $past(stop_mode_in) == 2'h3 && stop_mode_in == 2'h3
    |-> wake_out) else $error("wake lost in stop");
  loop_pin_a: assert property (wr_in && addr_in == UNLSW_ADDR_CTRL1 && stop_mode_in == 2'h0
    |=> rx_pin_used_out != $past(wdata_in[UNLSW_C1_LOOP])) else $error("rx pin use wrong");
  start_hold_a: assert property ($fell(tx_pin_out) && tx_pin_oe_out && stop_mode_in == 2'h0
    |-> (!tx_pin_out || stop_mode_in != 2'h0)[*8]) else $error("bit too short");
  ctrl3_back_a: assert property (wr_in && addr_in == UNLSW_ADDR_CTRL3 && stop_mode_in == 2'h0 ##1 !wr_in
    ##1 rd_in && addr_in == UNLSW_ADDR_CTRL3 && stop_mode_in == 2'h0
    |=> rdata_out[6:4] == $past(wdata_in[6:4], 3)) else $error("control three readback");
  cover property (wake_out);
  cover property (stop_mode_in == 2'h3 ##1 stop_mode_in == 2'h3);
  cover property (!rx_pin_used_out && tx_pin_oe_out);
endmodule
bind unlsw_core unlsw_chk unlsw_chk_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stop_mode_in(stop_mode_in),
  .rx_pin_in(rx_pin_in), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
  .rx_pin_used_out(rx_pin_used_out), .wake_out(wake_out));

// File: test/unlsw_peer.sv
// Far-end serial device: sends frames and captures what it hears.
// Assumes one bit lasts BIT clocks; its line idles high as with a pull-up.
`timescale 1ns/10ps
module unlsw_peer #(
  parameter int BIT = 32
) (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic nine_in,
  output logic line_out,
  output logic [9:0] frame_out,
  output int n_frame_out
);
  initial begin
    line_out = 1'b1;
    n_frame_out = 0;
  end
  task automatic send(input logic [8:0] v, input int nb);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      line_out <= v[i];
      repeat (BIT) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk_in);
  endtask
  always begin
    int nb;
    logic [9:0] fr;
    @(negedge line_in);
    nb = nine_in ? 9 : 8;
    fr = 10'h000;
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i <= nb; i++) begin
      repeat (BIT) @(posedge clk_in);
      fr[i] = line_in;
    end
    frame_out = fr;
    n_frame_out++;
  end
endmodule

// File: test/unlsw_core_tb.sv
// Self-checking bench for the serial core.
// Assumes the core, its package, the peer model and the bound checker.
`timescale 1ns/10ps
module unlsw_core_tb;
  import unlsw_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0, nine_q = 1'b0;
  logic [1:0] stop_mode_in = 2'h0;
  logic [7:0] rdata_out, b;
  logic tx_pin_out, tx_pin_oe_out, rx_pin_used_out, wake_out, peer_line;
  logic [9:0] peer_frame;
  logic [31:0] seed = 32'h18;
  logic [15:0] er;
  logic [15:0] exp_rd[$];
  logic [9:0] exp_fr[$];
  int n_frames;
  int n_mismatch = 0;
  int total_checks = 0;
  // Half-duplex line: whoever is enabled drives it
  wire logic tx_line = tx_pin_oe_out ? tx_pin_out : peer_line;
  wire logic peer_in = tx_pin_oe_out ? tx_pin_out : 1'b1;
  always #5 clk_in = ~clk_in;
  unlsw_core unlsw_core_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stop_mode_in(stop_mode_in), .rx_pin_in(peer_line),
    .tx_pin_in(tx_line), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
    .rx_pin_used_out(rx_pin_used_out), .wake_out(wake_out));
  unlsw_peer unlsw_peer_inst (.clk_in(clk_in), .line_in(peer_in), .nine_in(nine_q), .line_out(peer_line),
    .frame_out(peer_frame), .n_frame_out(n_frames));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] v, input logic [9:0] e, input string s);
    total_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_rd.push_back({m, e});
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic tx(input logic [8:0] v);
    int n;
    n = n_frames + 1;
    exp_fr.push_back(nine_q ? {1'b1, v} : {2'b01, v[7:0]});
    wr(UNLSW_ADDR_DATA, v[7:0]);
    for (int i = 0; i < 800 && n_frames < n; i++) @(posedge clk_in);
    if (n_frames < n) begin
      n_mismatch++;
      end_of_test();
    end
    repeat (16) @(posedge clk_in);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk_in) begin
    rd_q <= rd_in;
    if (rd_q) begin
      er = exp_rd.pop_front();
      chk(rdata_out & er[15:8], er[7:0], "read data");
    end
  end
  always @(n_frames) chk(peer_frame, exp_fr.pop_front(), "frame");
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    rd(UNLSW_ADDR_BAUD, 8'hff, UNLSW_BAUD_RST);
    rd(3'h7, 8'hff, 8'h00);
    wr(UNLSW_ADDR_CTRL2, 8'h0c);
    tx({1'b0, xs()});
    wr(UNLSW_ADDR_CTRL1, 8'h10);
    nine_q = 1'b1;
    wr(UNLSW_ADDR_CTRL3, 8'h40);
    rd(UNLSW_ADDR_CTRL3, 8'h70, 8'h40);
    tx({1'b1, xs()});
    tx({1'b1, xs()});
    wr(UNLSW_ADDR_CTRL3, 8'h00);
    tx({1'b0, xs()});
    b = xs();
    unlsw_peer_inst.send({1'b1, b}, 9);
    rd(UNLSW_ADDR_STAT, 8'h21, 8'h21);
    rd(UNLSW_ADDR_CTRL3, 8'h80, 8'h80);
    rd(UNLSW_ADDR_DATA, 8'hff, b);
    wr(UNLSW_ADDR_STAT, 8'h01);
    rd(UNLSW_ADDR_STAT, 8'h01, 8'h00);
    nine_q = 1'b0;
    wr(UNLSW_ADDR_CTRL1, 8'h80);
    b = xs();
    tx({1'b0, b});
    rd(UNLSW_ADDR_DATA, 8'hff, b);
    wr(UNLSW_ADDR_CTRL1, 8'ha0);
    wr(UNLSW_ADDR_CTRL3, 8'h20);
    b = xs();
    tx({1'b0, b});
    rd(UNLSW_ADDR_DATA, 8'hff, b);
    wr(UNLSW_ADDR_CTRL3, 8'h00);
    b = xs();
    unlsw_peer_inst.send({1'b0, b}, 8);
    rd(UNLSW_ADDR_DATA, 8'hff, b);
    wr(UNLSW_ADDR_CTRL1, 8'h00);
    wr(UNLSW_ADDR_CTRL3, 8'h10);
    wr(UNLSW_ADDR_STAT, 8'h01);
    stop_mode_in <= UNLSW_STOP_THREE;
    @(posedge clk_in);
    chk(wake_out, 1'b0, "wake early");
    unlsw_peer_inst.send({1'b0, xs()}, 8);
    chk(wake_out, 1'b1, "wake");
    stop_mode_in <= UNLSW_STOP_NONE;
    @(posedge clk_in);
    rd(UNLSW_ADDR_CTRL3, 8'h7f, 8'h10);
    for (int m = 1; m < 3; m++) begin
      wr(UNLSW_ADDR_BAUD, 8'h03);
      stop_mode_in <= m[1:0];
      repeat (2) @(posedge clk_in);
      stop_mode_in <= UNLSW_STOP_NONE;
      @(posedge clk_in);
      rd(UNLSW_ADDR_BAUD, 8'hff, UNLSW_BAUD_RST);
      rd(UNLSW_ADDR_CTRL2, 8'hff, 8'h00);
    end
    @(posedge clk_in);
    end_of_test();
  end
endmodule
